// [hw/nalu_top.sv]
// nibble alu with work register addressing and status flags
`timescale 1ns/1ps
module nalu_top
    import nalu_pkg::*;
#(
    parameter int NIBBLE_BITS = NIB_W
)(
    // clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        reset,
    // instruction request
    input  wire logic                        start,
    input  nalu_pkg::nalu_op_t               opCode,
    input  wire logic                        immForm,
    input  wire logic [nalu_pkg::COL_W-1:0]  regColumn,
    input  wire logic [nalu_pkg::ROW_W+nalu_pkg::COL_W-1:0] memOperand,
    input  wire logic [nalu_pkg::NIB_W-1:0]  immData,
    output logic                             busy,
    output logic                             done,
    output logic                             skipNext,
    // data memory
    output logic [nalu_pkg::ADDR_W-1:0]      memAddr,
    output logic                             memRd,
    input  wire logic [nalu_pkg::NIB_W-1:0]  memRdData,
    output logic                             memWr,
    output logic [nalu_pkg::NIB_W-1:0]       memWrData,
    // software register port
    input  wire logic [nalu_pkg::RADDR_W-1:0] regAddr,
    input  wire logic [nalu_pkg::RDATA_W-1:0] regWrData,
    input  wire logic                        regWr,
    input  wire logic                        regRd,
    output logic [nalu_pkg::RDATA_W-1:0]     regRdData
);
    import nalu_pkg::*;

    if (NIBBLE_BITS != NIB_W) begin : g_width_check
        $error("nalu_top serves only four-bit nibbles");
    end

    nalu_state_t state_reg;
    nalu_state_t state_next;
    nalu_op_t    op_reg;
    logic              immForm_reg;
    logic [COL_W-1:0]  regColumn_reg;
    logic [ROW_W+COL_W-1:0] memOperand_reg;
    logic [NIB_W-1:0]  tmpA_reg;
    logic [NIB_W-1:0]  tmpB_reg;

    logic              ixeFlag_reg, zeroFlag_reg, carryFlag_reg;
    logic              cmpFlag_reg, bcdFlag_reg, mpeFlag_reg;
    logic [PTR_W-1:0]  workPtr_reg;
    logic [BANK_W-1:0] bank_reg;
    logic [ADDR_W-1:0] index_reg;
    logic [PTR_W-1:0]  rowPtr_reg;

    logic [ADDR_W-1:0] workAddr, dataAddr, indAddr;
    logic [ADDR_W-1:0] addrA, addrB, addrW;
    logic [NIB_W-1:0]  sumOut;
    logic              carryOut;
    logic              isArith, isSub, useCarry, needB, doWrite, skipHit;
    logic [NIB_W-1:0]  result;

    nalu_addr u_addr (
        .workPtr      (workPtr_reg),
        .bankSel      (bank_reg),
        .indexValue   (index_reg),
        .indexEnable  (ixeFlag_reg),
        .rowPointer   (rowPtr_reg),
        .rowPtrEnable (mpeFlag_reg),
        .regColumn    (regColumn_reg),
        .memOperand   (memOperand_reg),
        .indColumn    (tmpA_reg),
        .workAddr     (workAddr),
        .dataAddr     (dataAddr),
        .indAddr      (indAddr)
    );

    nalu_adder u_adder (
        .opA      (tmpA_reg),
        .opB      (tmpB_reg),
        .carryIn  (useCarry & carryFlag_reg),
        .subtract (isSub),
        .decimal  (bcdFlag_reg),
        .sumOut   (sumOut),
        .carryOut (carryOut)
    );

    assign busy = (state_reg != S_IDLE);

    // operation decode
    always_comb begin
        isArith  = 1'b0;
        isSub    = 1'b0;
        useCarry = 1'b0;
        unique case (op_reg)
            OP_ADD:      isArith = 1'b1;
            OP_SUM_CIN:  begin isArith = 1'b1; useCarry = 1'b1; end
            OP_SUB:      begin isArith = 1'b1; isSub = 1'b1; end
            OP_DIFF_BIN: begin isArith = 1'b1; isSub = 1'b1; useCarry = 1'b1; end
            default:     isArith = 1'b0;
        endcase
    end

    // first operand is the work register unless the form is immediate or a test; rotate always takes the work register
    always_comb begin
        addrA = workAddr;
        needB = 1'b1;
        unique case (op_reg)
            OP_SKIP_TRUE, OP_SKIP_FALSE, OP_SKIP_EQ, OP_SKIP_NE,
            OP_SKIP_GE, OP_SKIP_LT, OP_MOVE_IMM: begin
                addrA = dataAddr;
                needB = 1'b0;
            end
            OP_ROTATE_CARRY: needB = 1'b0;
            default: begin
                if (immForm_reg) begin
                    addrA = dataAddr;
                    needB = 1'b0;
                end
            end
        endcase
        addrB = (op_reg == OP_IND_TO_MEM) ? indAddr : dataAddr;
    end

    // result, destination and skip decision
    always_comb begin
        result  = tmpA_reg;
        addrW   = immForm_reg ? dataAddr : workAddr;
        doWrite = 1'b1;
        skipHit = 1'b0;
        unique case (op_reg)
            OP_ADD, OP_SUM_CIN, OP_SUB, OP_DIFF_BIN: begin
                result  = sumOut;
                doWrite = ~cmpFlag_reg;
            end
            OP_AND:          result = tmpA_reg & tmpB_reg;
            OP_OR:           result = tmpA_reg | tmpB_reg;
            OP_XOR:          result = tmpA_reg ^ tmpB_reg;
            OP_LOAD_WORK:    begin result = tmpB_reg; addrW = workAddr; end
            OP_WRITE_BACK:   begin result = tmpA_reg; addrW = dataAddr; end
            OP_MOVE_IMM:     begin result = tmpB_reg; addrW = dataAddr; end
            OP_IND_FROM_MEM: begin result = tmpB_reg; addrW = indAddr; end
            OP_IND_TO_MEM:   begin result = tmpB_reg; addrW = dataAddr; end
            OP_ROTATE_CARRY: begin
                result = {carryFlag_reg, tmpA_reg[NIB_W-1:1]};
                addrW  = workAddr;
            end
            OP_SKIP_TRUE:  begin doWrite = 1'b0; skipHit = (tmpA_reg & tmpB_reg) == tmpB_reg; end
            OP_SKIP_FALSE: begin doWrite = 1'b0; skipHit = (tmpA_reg & tmpB_reg) == '0; end
            OP_SKIP_EQ:    begin doWrite = 1'b0; skipHit = tmpA_reg == tmpB_reg; end
            OP_SKIP_NE:    begin doWrite = 1'b0; skipHit = tmpA_reg != tmpB_reg; end
            OP_SKIP_GE:    begin doWrite = 1'b0; skipHit = tmpA_reg >= tmpB_reg; end
            OP_SKIP_LT:    begin doWrite = 1'b0; skipHit = tmpA_reg < tmpB_reg; end
            default:       doWrite = 1'b0;
        endcase
    end

    // sequencer: fixed read latency of one cycle after the strobe is seen
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE:    if (start) state_next = S_ISSUE_A;
            S_ISSUE_A: state_next = S_WAIT_A;
            S_WAIT_A:  state_next = S_TAKE_A;
            S_TAKE_A:  state_next = needB ? S_ISSUE_B : S_EXEC;
            S_ISSUE_B: state_next = S_WAIT_B;
            S_WAIT_B:  state_next = S_TAKE_B;
            S_TAKE_B:  state_next = S_EXEC;
            S_EXEC:    state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= S_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // request capture and hidden holding registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            op_reg         <= OP_ADD;
            immForm_reg    <= 1'b0;
            regColumn_reg  <= '0;
            memOperand_reg <= '0;
            tmpA_reg       <= '0;
            tmpB_reg       <= '0;
        end else if (state_reg == S_IDLE && start) begin
            op_reg         <= opCode;
            immForm_reg    <= immForm;
            regColumn_reg  <= regColumn;
            memOperand_reg <= memOperand;
            tmpB_reg       <= immData;
        end else if (state_reg == S_TAKE_A) begin
            tmpA_reg <= memRdData;
        end else if (state_reg == S_TAKE_B) begin
            tmpB_reg <= memRdData;
        end
    end

    // memory strobes and data come from flops
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            memAddr   <= '0;
            memRd     <= 1'b0;
            memWr     <= 1'b0;
            memWrData <= '0;
        end else begin
            memRd <= 1'b0;
            memWr <= 1'b0;
            if (state_reg == S_ISSUE_A) begin
                memAddr <= addrA;
                memRd   <= 1'b1;
            end else if (state_reg == S_ISSUE_B) begin
                memAddr <= addrB;
                memRd   <= 1'b1;
            end else if (state_reg == S_EXEC && doWrite) begin
                memAddr   <= addrW;
                memWr     <= 1'b1;
                memWrData <= result;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            done     <= 1'b0;
            skipNext <= 1'b0;
        end else begin
            done     <= (state_reg == S_EXEC);
            skipNext <= (state_reg == S_EXEC) && skipHit;
        end
    end

    // flags: an instruction's own update wins over a software write
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ixeFlag_reg   <= RST_STATUS[ST_INDEX_EN];
            zeroFlag_reg  <= RST_STATUS[ST_ZERO];
            carryFlag_reg <= RST_STATUS[ST_CARRY];
            cmpFlag_reg   <= RST_STATUS[ST_COMPARE];
            bcdFlag_reg   <= RST_STATUS[ST_DECIMAL];
            mpeFlag_reg   <= RST_STATUS[ST_ROWP_EN];
        end else if (state_reg == S_EXEC && isArith) begin
            carryFlag_reg <= carryOut;
            if (!cmpFlag_reg) begin
                zeroFlag_reg <= (sumOut == '0);
            end else if (sumOut != '0) begin
                zeroFlag_reg <= 1'b0;
            end
        end else if (state_reg == S_EXEC && op_reg == OP_ROTATE_CARRY) begin
            carryFlag_reg <= tmpA_reg[0];
        end else if (regWr && regAddr == REG_STATUS) begin
            // other instructions never reach the flags
            ixeFlag_reg   <= regWrData[ST_INDEX_EN];
            zeroFlag_reg  <= regWrData[ST_ZERO];
            carryFlag_reg <= regWrData[ST_CARRY];
            cmpFlag_reg   <= regWrData[ST_COMPARE];
            bcdFlag_reg   <= regWrData[ST_DECIMAL];
            mpeFlag_reg   <= regWrData[ST_ROWP_EN];
        end
    end

    // pointer registers; changing them mid-instruction moves later addresses
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            workPtr_reg <= RST_WORKPTR;
            bank_reg    <= RST_BANK;
            index_reg   <= RST_INDEX;
            rowPtr_reg  <= RST_ROWPTR;
        end else if (regWr) begin
            unique case (regAddr)
                REG_WORKPTR: workPtr_reg <= regWrData[PTR_W-1:0];
                REG_BANK:    bank_reg    <= regWrData[BANK_W-1:0];
                REG_INDEX:   index_reg   <= regWrData[ADDR_W-1:0];
                REG_ROWPTR:  rowPtr_reg  <= regWrData[PTR_W-1:0];
                default:     ;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            regRdData <= '0;
        end else if (regRd) begin
            unique case (regAddr)
                REG_STATUS:  regRdData <= {10'h000, mpeFlag_reg, bcdFlag_reg, cmpFlag_reg,
                                           carryFlag_reg, zeroFlag_reg, ixeFlag_reg};
                REG_WORKPTR: regRdData <= {9'h000, workPtr_reg};
                REG_BANK:    regRdData <= {12'h000, bank_reg};
                REG_INDEX:   regRdData <= {5'h00, index_reg};
                REG_ROWPTR:  regRdData <= {9'h000, rowPtr_reg};
                default:     regRdData <= '0;
            endcase
        end else begin
            regRdData <= '0;
        end
    end
endmodule

// [hw/nalu_pkg.sv]
// shared constants and types of the nibble alu
package nalu_pkg;
    localparam int NIB_W   = 4;
    localparam int BANK_W  = 4;
    localparam int ROW_W   = 3;
    localparam int COL_W   = 4;
    localparam int PTR_W   = BANK_W + ROW_W;
    localparam int ADDR_W  = PTR_W + COL_W;
    localparam int RADDR_W = 4;
    localparam int RDATA_W = 16;

    // register offsets of the plain software port
    localparam logic [3:0] REG_STATUS  = 4'h0;
    localparam logic [3:0] REG_WORKPTR = 4'h1;
    localparam logic [3:0] REG_BANK    = 4'h2;
    localparam logic [3:0] REG_INDEX   = 4'h3;
    localparam logic [3:0] REG_ROWPTR  = 4'h4;

    // status register bit positions
    localparam int ST_INDEX_EN = 0;
    localparam int ST_ZERO     = 1;
    localparam int ST_CARRY    = 2;
    localparam int ST_COMPARE  = 3;
    localparam int ST_DECIMAL  = 4;
    localparam int ST_ROWP_EN  = 5;

    // reset values
    localparam logic [5:0]        RST_STATUS  = 6'h00;
    localparam logic [PTR_W-1:0]  RST_WORKPTR = 7'h00;
    localparam logic [BANK_W-1:0] RST_BANK    = 4'h0;
    localparam logic [ADDR_W-1:0] RST_INDEX   = 11'h000;
    localparam logic [PTR_W-1:0]  RST_ROWPTR  = 7'h00;

    // decimal correction constants
    localparam logic [4:0] DEC_LIMIT  = 5'h09;
    localparam logic [4:0] DEC_ADJUST = 5'h06;

    typedef enum logic [4:0] {
        OP_ADD, OP_SUM_CIN, OP_SUB, OP_DIFF_BIN,
        OP_AND, OP_OR, OP_XOR,
        OP_LOAD_WORK, OP_WRITE_BACK, OP_MOVE_IMM,
        OP_IND_FROM_MEM, OP_IND_TO_MEM,
        OP_ROTATE_CARRY,
        OP_SKIP_TRUE, OP_SKIP_FALSE, OP_SKIP_EQ, OP_SKIP_NE, OP_SKIP_GE, OP_SKIP_LT
    } nalu_op_t;

    typedef enum logic [2:0] {
        S_IDLE, S_ISSUE_A, S_WAIT_A, S_TAKE_A, S_ISSUE_B, S_WAIT_B, S_TAKE_B, S_EXEC
    } nalu_state_t;
endpackage

// [hw/nalu_adder.sv]
// four-bit adder and subtractor with decimal correction
`timescale 1ns/1ps
module nalu_adder
    import nalu_pkg::*;
(
    // operands
    input  wire logic [NIB_W-1:0] opA,
    input  wire logic [NIB_W-1:0] opB,
    input  wire logic             carryIn,
    input  wire logic             subtract,
    input  wire logic             decimal,
    // result
    output logic      [NIB_W-1:0] sumOut,
    output logic                  carryOut
);
    logic [4:0] raw;
    logic [4:0] adj;

    always_comb begin
        if (subtract) begin
            raw = {1'b0, opA} - {1'b0, opB} - {4'h0, carryIn};
        end else begin
            raw = {1'b0, opA} + {1'b0, opB} + {4'h0, carryIn};
        end
        adj = raw;
        carryOut = raw[4];
        if (decimal) begin
            if (subtract && raw[4]) begin
                adj = raw - DEC_ADJUST;
            end else if (!subtract && raw > DEC_LIMIT) begin
                adj = raw + DEC_ADJUST;
                carryOut = 1'b1;
            end
        end
        sumOut = adj[NIB_W-1:0];
    end
endmodule

// [hw/nalu_addr.sv]
// address former for work register, data memory and indirect targets
`timescale 1ns/1ps
module nalu_addr
    import nalu_pkg::*;
(
    // pointers and modifiers
    input  wire logic [PTR_W-1:0]  workPtr,
    input  wire logic [BANK_W-1:0] bankSel,
    input  wire logic [ADDR_W-1:0] indexValue,
    input  wire logic              indexEnable,
    input  wire logic [PTR_W-1:0]  rowPointer,
    input  wire logic              rowPtrEnable,
    // operands
    input  wire logic [COL_W-1:0]  regColumn,
    input  wire logic [ROW_W+COL_W-1:0] memOperand,
    input  wire logic [COL_W-1:0]  indColumn,
    // addresses
    output logic      [ADDR_W-1:0] workAddr,
    output logic      [ADDR_W-1:0] dataAddr,
    output logic      [ADDR_W-1:0] indAddr
);
    logic [ADDR_W-1:0] dataBase;
    logic [ADDR_W-1:0] indBase;
    logic [ADDR_W-1:0] indexMask;

    // work register bank and row never follow the selected data bank
    assign workAddr  = {workPtr, regColumn};
    assign indexMask = indexEnable ? indexValue : '0;
    assign dataBase  = {bankSel, memOperand};
    assign dataAddr  = dataBase | indexMask;
    // row pointer replaces bank and row only for indirect targets
    assign indBase   = rowPtrEnable ? {rowPointer, indColumn}
                                    : {bankSel, memOperand[ROW_W+COL_W-1:COL_W], indColumn};
    assign indAddr   = indBase | indexMask;
endmodule

// [dv/nalu_top_checker.sv]
// concurrent checks on the nibble alu ports
`timescale 1ns/1ps
module nalu_top_checker
    import nalu_pkg::*;
#(
    parameter int NIBBLE_BITS = NIB_W
)(
    // clock and reset
    input wire logic                   clk_sys,
    input wire logic                   reset,
    // instruction side
    input wire logic                   start,
    input nalu_pkg::nalu_op_t          opCode,
    input wire logic                   immForm,
    input wire logic [COL_W-1:0]       regColumn,
    input wire logic [NIB_W-1:0]       immData,
    input wire logic                   busy,
    input wire logic                   done,
    input wire logic                   skipNext,
    // data memory
    input wire logic [ADDR_W-1:0]      memAddr,
    input wire logic                   memRd,
    input wire logic [NIB_W-1:0]       memRdData,
    input wire logic                   memWr,
    input wire logic [NIB_W-1:0]       memWrData,
    // register port
    input wire logic [RADDR_W-1:0]     regAddr,
    input wire logic                   regRd,
    input wire logic [RDATA_W-1:0]     regRdData
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic go;
    assign go = start && !busy;

    work_col_a: assert property (go && !immForm && opCode inside {OP_ADD, OP_SUM_CIN,
        OP_SUB, OP_DIFF_BIN, OP_AND, OP_OR, OP_XOR}
        |-> ##2 memRd && memAddr[3:0] == $past(regColumn, 2))
        else $error("work register column not taken from operand");
    arith_lat_a: assert property (go && !immForm && opCode inside {OP_ADD, OP_SUM_CIN,
        OP_SUB, OP_DIFF_BIN} |=> !done [*7] ##1 done)
        else $error("arithmetic finish time wrong");
    skip_lat_a: assert property (go && opCode inside {OP_SKIP_TRUE, OP_SKIP_FALSE,
        OP_SKIP_EQ, OP_SKIP_NE, OP_SKIP_GE, OP_SKIP_LT} |-> ##5 done && !memWr)
        else $error("test wrote");
    rot_addr_a: assert property (go && opCode == OP_ROTATE_CARRY |-> ##2 (memRd &&
        memAddr[3:0] == $past(regColumn, 2)) ##3 (done && memWr && memAddr == $past(memAddr, 3)))
        else $error("rotate target wrong");
    imm_dest_a: assert property (go && immForm && opCode inside {OP_AND, OP_OR, OP_XOR}
        |-> ##5 done && memWr && memAddr == $past(memAddr, 3))
        else $error("immediate form not written to memory operand");
    and_data_a: assert property (go && immForm && opCode == OP_AND |-> ##5
        memWrData == ($past(memRdData, 2) & $past(immData, 5))) else $error("and wrong");
    wr_done_a: assert property (memWr |-> done) else $error("write outside finish");
    skip_done_a: assert property (skipNext |-> done) else $error("skip outside finish");
    busy_hold_a: assert property (go |=> busy [*4]) else $error("busy dropped early");
    rd_idle_a: assert property (!$past(regRd) |-> regRdData == 16'h0000)
        else $error("read data outside read slot");
    unmapped_a: assert property ($past(regRd) && $past(regAddr) > 4'h4
        |-> regRdData == 16'h0000) else $error("unmapped read not zero");

    cover property (done && skipNext);
    cover property (done && memWr);
    cover property (go && immForm);
endmodule

bind nalu_top nalu_top_checker #(.NIBBLE_BITS(NIBBLE_BITS)) chk (
    .clk_sys(clk_sys), .reset(reset), .start(start), .opCode(opCode), .immForm(immForm),
    .regColumn(regColumn), .immData(immData), .busy(busy), .done(done), .skipNext(skipNext),
    .memAddr(memAddr), .memRd(memRd), .memRdData(memRdData), .memWr(memWr),
    .memWrData(memWrData), .regAddr(regAddr), .regRd(regRd), .regRdData(regRdData));

// [dv/testbench.sv]
// self-checking bench for the nibble alu
`timescale 1ns/1ps
module testbench;
    import nalu_pkg::*;
    logic       clk_sys = 1'h0, reset = 1'h1, start = 1'h0, immForm = 1'h0, busy, done, skipNext;
    nalu_op_t   opCode = OP_ADD, op;
    logic [3:0] regColumn = 4'h0, immData = 4'h0, memRdData = 4'h0, memWrData, regAddr = 4'h0;
    logic [6:0] memOperand = 7'h00, wp = 7'h00, rp = 7'h00;
    logic [10:0] memAddr, ix = 11'h000;
    logic       memRd, memWr, regWr = 1'h0, regRd = 1'h0, rdPend = 1'h0, poke = 1'h0, im;
    logic [15:0] regWrData = 16'h0000, regRdData;
    logic [3:0] mem [2048], sh [2048], bank = 4'h0;
    logic [5:0] st = 6'h00;
    logic [17:0] notes [$];
    int         errors = 0, checked = 0, i;

    always #12.5 clk_sys = ~clk_sys;

    nalu_top #(.NIBBLE_BITS(NIB_W)) dut (.clk_sys(clk_sys), .reset(reset), .start(start),
        .opCode(opCode), .immForm(immForm), .regColumn(regColumn), .memOperand(memOperand),
        .immData(immData), .busy(busy), .done(done), .skipNext(skipNext), .memAddr(memAddr),
        .memRd(memRd), .memRdData(memRdData), .memWr(memWr), .memWrData(memWrData),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData));

    task automatic close_out;
        // an expected result that never showed up is a miss as well
        check("notesLeft", 18'(notes.size()), 18'h00000);
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(string nm, logic [17:0] seen, logic [17:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // memory answers one cycle after the read strobe, scrambled otherwise
    always @(posedge clk_sys) begin
        if (memWr) mem[memAddr] <= memWrData;
        memRdData <= memRd ? mem[memAddr] : ~memRdData;
        rdPend <= regRd;
        if (rdPend || done) begin
            if (notes.size() == 0) check("noteCount", 18'h00000, 18'h00001);
            else check(rdPend ? "regRdData" : "result", rdPend ? {2'h2, regRdData} : {1'h0,
                skipNext, memWr, memWr ? {memAddr, memWrData} : 15'h0000}, notes.pop_front());
        end
    end

    task automatic regw(logic [3:0] a, logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'h1;
        @(posedge clk_sys);
        regWr <= 1'h0;
        case (a)
            REG_STATUS:  st = d[5:0];
            REG_WORKPTR: wp = d[6:0];
            REG_BANK:    bank = d[3:0];
            REG_INDEX:   ix = d[10:0];
            REG_ROWPTR:  rp = d[6:0];
            default:     ;
        endcase
    endtask

    task automatic regr(logic [3:0] a);
        logic [15:0] e;
        case (a)
            REG_STATUS:  e = {10'h000, st};
            REG_WORKPTR: e = {9'h000, wp};
            REG_BANK:    e = {12'h000, bank};
            REG_INDEX:   e = {5'h00, ix};
            REG_ROWPTR:  e = {9'h000, rp};
            default:     e = 16'h0000;
        endcase
        notes.push_back({2'h2, e});
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge clk_sys);
        regRd <= 1'h0;
    endtask

    task automatic exec(nalu_op_t o, logic m1, logic [3:0] r, logic [6:0] m, logic [3:0] n);
        logic [10:0] wa, da, ia, wad;
        logic [4:0]  raw;
        logic [3:0]  a, b, res;
        logic        wr, sk;
        int          k;
        wa = {wp, r};
        da = {bank, m} | (st[0] ? ix : 11'h000);
        ia = (st[5] ? {rp, sh[wa]} : {bank, m[6:4], sh[wa]}) | (st[0] ? ix : 11'h000);
        a = m1 ? sh[da] : sh[wa];
        b = m1 ? n : sh[da];
        wad = m1 ? da : wa;
        wr = 1'h1;
        sk = 1'h0;
        res = 4'h0;
        case (o)
            OP_ADD, OP_SUM_CIN: begin
                raw = a + b + ((o == OP_SUM_CIN) ? st[2] : 1'h0);
                res = raw[3:0];
                st[2] = raw[4];
                if (st[4] && raw > 5'h09) begin
                    res = raw[3:0] + 4'h6;
                    st[2] = 1'h1;
                end
            end
            OP_SUB, OP_DIFF_BIN: begin
                raw = {1'h0, a} - b - ((o == OP_DIFF_BIN) ? st[2] : 1'h0);
                res = raw[3:0];
                st[2] = raw[4];
                if (st[4] && raw[4]) res = res - 4'h6;
            end
            OP_AND:          res = a & b;
            OP_OR:           res = a | b;
            OP_XOR:          res = a ^ b;
            OP_LOAD_WORK:    begin wad = wa; res = sh[da]; end
            OP_WRITE_BACK:   begin wad = da; res = sh[wa]; end
            OP_MOVE_IMM:     begin wad = da; res = n; end
            OP_IND_FROM_MEM: begin wad = ia; res = sh[da]; end
            OP_IND_TO_MEM:   begin wad = da; res = sh[ia]; end
            OP_ROTATE_CARRY: begin
                res = {st[2], sh[wa][3:1]};
                st[2] = sh[wa][0];
            end
            default: begin
                wr = 1'h0;
                case (o)
                    OP_SKIP_TRUE:  sk = (sh[da] & n) == n;
                    OP_SKIP_FALSE: sk = (sh[da] & n) == 4'h0;
                    OP_SKIP_EQ:    sk = sh[da] == n;
                    OP_SKIP_NE:    sk = sh[da] != n;
                    OP_SKIP_GE:    sk = sh[da] >= n;
                    default:       sk = sh[da] < n;
                endcase
            end
        endcase
        if (o <= OP_DIFF_BIN) begin
            wr = !st[3];
            st[1] = (res == 4'h0) && (st[1] || !st[3]);
        end
        if (wr) sh[wad] = res;
        notes.push_back({1'h0, sk, wr, wr ? {wad, res} : 15'h0000});
        @(posedge clk_sys);
        start <= 1'h1;
        opCode <= o;
        immForm <= m1;
        regColumn <= r;
        memOperand <= m;
        immData <= n;
        @(posedge clk_sys);
        start <= 1'h0;
        if (poke) begin
            @(posedge clk_sys);
            start <= 1'h1;
            @(posedge clk_sys);
            start <= 1'h0;
        end
        for (k = 0; k < 20 && done !== 1'h1; k++) @(negedge clk_sys);
        if (k == 20) check("done", 18'h00000, 18'h00001);
    endtask

    initial begin
        void'($urandom(68));
        for (i = 0; i < 2048; i++) begin
            mem[i] = 4'($urandom);
            sh[i] = mem[i];
        end
        repeat (4) @(posedge clk_sys);
        reset <= 1'h0;
        regw(4'hf, 16'hffff);
        for (i = 0; i < 6; i++) regr(4'(i * 3 % 16));
        for (i = 0; i < 5; i++) regw(4'(i), 16'($urandom));
        for (i = 0; i < 6; i++) regr(i == 5 ? 4'hf : 4'(i));
        $display("test registers done");
        // each operation about twenty times with random flags, modes and pointers
        for (i = 0; i < 400; i++) begin
            op = nalu_op_t'(i % 19);
            if (i % 19 == 0) begin
                regw(REG_WORKPTR, 16'($urandom));
                regw(REG_BANK, 16'($urandom));
                regw(REG_INDEX, 16'($urandom));
                regw(REG_ROWPTR, 16'($urandom));
            end
            regw(REG_STATUS, 16'($urandom));
            im = (op >= OP_SKIP_TRUE || op == OP_MOVE_IMM) ? 1'h1 :
                 (op < OP_LOAD_WORK) ? 1'($urandom) : 1'h0;
            exec(op, im, 4'($urandom), 7'($urandom), 4'($urandom));
            regr(REG_STATUS);
        end
        $display("test instruction sweep done");
        poke = 1'h1;
        exec(OP_ADD, 1'h0, 4'h1, 7'h12, 4'h0);
        poke = 1'h0;
        repeat (12) @(posedge clk_sys);
        regr(REG_STATUS);
        $display("test busy refusal done");
        repeat (4) @(posedge clk_sys);
        close_out;
    end

    initial begin
        #(30000 * 25);
        check("watchdog", 18'h00000, 18'h00001);
        close_out;
    end
endmodule
